// file: src/lwc_pkg.sv
/*
  Package for the low-power wake controller: register map, field
  positions, state encodings, carrier structs and timing counts.
  Assumes a 100 MHz core clock and an 8-bit APB address.
*/
package lwc_pkg;

  // Register byte addresses
  localparam logic [7:0] IOC_OFFSET = 8'hc8;
  localparam logic [7:0] IRQ_EN_OFFSET = 8'hcc;
  localparam logic [7:0] PORT_A_OFFSET = 8'hd0;
  localparam logic [7:0] PORT_B_OFFSET = 8'hd4;
  localparam logic [7:0] PORT_C_OFFSET = 8'hd8;
  localparam logic [7:0] STATUS_OFFSET = 8'hdc;

  // Interrupt option control fields
  localparam int unsigned IOC_GEN_BIT = 4;

  // Peripheral enable register fields
  localparam int unsigned EN_TIMER_BIT = 0;
  localparam int unsigned EN_CONV_BIT = 1;
  localparam int unsigned EN_RLD_OVF_BIT = 2;
  localparam int unsigned EN_CMP_BIT = 3;
  localparam int unsigned EN_EDGE_BIT = 4;
  localparam int unsigned EN_WDG_SOFT_BIT = 8;
  localparam int unsigned EN_OSC_SEL_BIT = 9;

  // Port config fields: option byte low, data byte above
  localparam int unsigned CFG_OPT_LSB = 0;
  localparam int unsigned CFG_DAT_LSB = 8;

  // Status register fields
  localparam int unsigned ST_PWR_LSB = 0;
  localparam int unsigned ST_RES_LSB = 2;
  localparam int unsigned ST_NMI_BIT = 4;
  localparam int unsigned ST_VEC_LSB = 5;
  localparam int unsigned ST_WDG_BIT = 10;

  // Vector numbering towards the core
  localparam int unsigned VEC_NMI = 0;
  localparam int unsigned VEC_PORT_AB = 1;
  localparam int unsigned VEC_PORT_C = 2;
  localparam int unsigned VEC_RELOAD = 3;
  localparam int unsigned VEC_TIMER = 4;

  // Timing: oscillator stabilisation after stop
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STAB_TIME_NS = 81920;
  localparam int unsigned STAB_CYCLES_DFLT =
    (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STAB_CNT_W = 16;

  // Power states
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_STOP = 2'b10,
    PWR_STAB = 2'b11
  } lwc_pwr_t;

  // Core execution context
  typedef enum logic [1:0] {
    CORE_NORMAL = 2'b00,
    CORE_IRQ = 2'b01,
    CORE_NMI = 2'b10
  } lwc_core_mode_t;

  // Where execution continues after a wake
  typedef enum logic [1:0] {
    RES_SERVICE_THEN_NEXT = 2'b00,
    RES_NEXT_STAY_NMI = 2'b01,
    RES_NEXT_IN_ROUTINE = 2'b10,
    RES_NMI_THEN_ROUTINE = 2'b11
  } lwc_resume_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } lwc_apb_req_t;

  // Peripheral event flags, same clock domain
  typedef struct packed {
    logic timer_zero_flag;
    logic converter_eoc_flag;
    logic reload_overflow_flag;
    logic compare_match_flag;
    logic input_edge_flag;
  } lwc_periph_flags_t;

  // Whole state of the wake controller
  typedef struct packed {
    lwc_pwr_t pwr;
    lwc_core_mode_t saved_mode;
    lwc_resume_t resume;
    logic global_irq_enable;
    logic [4:0] irq_en;
    logic wdg_soft;
    logic osc_sel;
    logic [7:0] pa_opt;
    logic [7:0] pa_dat;
    logic [7:0] pb_opt;
    logic [7:0] pb_dat;
    logic [7:0] pc_opt;
    logic [7:0] pc_dat;
    logic nmi_latch;
    logic nmi_prev;
    logic wake_pulse;
    logic reject_pulse;
    logic stab_start;
    logic [31:0] prdata;
  } lwc_state_t;

  localparam lwc_state_t STATE_RESET = '0;

endpackage : lwc_pkg

// file: src/lwc_sync.sv
/*
  Two-flop synchroniser for a bus of asynchronous pin levels.
  Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/1ps
module lwc_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Both stages in one struct
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } lwc_sync_st_t;

  lwc_sync_st_t st;
  lwc_sync_st_t next_st;

  // First stage feeds only the second
  always_comb
  begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  // Register stages
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;

endmodule : lwc_sync

// file: src/lwc_stab_counter.sv
/*
  Oscillator stabilisation timer: a start pulse loads it, a done
  pulse marks expiry. Assumes start is a one-cycle pulse.
*/
`timescale 1ns/1ps
module lwc_stab_counter
  import lwc_pkg::*;
#(
  parameter int unsigned CYCLES = STAB_CYCLES_DFLT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic start,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic fin;
    logic [STAB_CNT_W-1:0] count;
  } lwc_stab_st_t;

  lwc_stab_st_t st;
  lwc_stab_st_t next_st;

  // Load, count down, pulse at zero
  always_comb
  begin
    next_st = st;
    next_st.fin = 1'b0;
    if (start)
    begin
      next_st.busy = 1'b1;
      next_st.count = STAB_CNT_W'(CYCLES - 1);
    end
    else if (st.busy)
    begin
      if (st.count == '0)
      begin
        next_st.busy = 1'b0;
        next_st.fin = 1'b1;
      end
      else
      begin
        next_st.count = st.count - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign done = st.fin;

endmodule : lwc_stab_counter

// file: src/lwc_wake_control.sv
/*
  Low-power wake controller: WAIT/STOP handling, wake qualification,
  vector request mapping and the APB register file.
  Assumes the core pulses wait_req/stop_req when it executes those
  instructions and reports its context on core_mode; pins are async.
*/
`timescale 1ns/1ps
module lwc_wake_control
  import lwc_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = STAB_CYCLES_DFLT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire lwc_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire logic wait_req,
  input wire logic stop_req,
  input wire lwc_core_mode_t core_mode,
  input wire logic nmi_ack,
  input wire logic watchdog_hw_option,
  output logic core_halt,
  output logic [4:0] irq_vector,
  output lwc_resume_t resume_action,
  output logic wake_done,
  output logic instr_rejected,
  // Oscillator
  output logic osc_enable,
  output logic osc_select,
  // Peripheral event flags
  input wire lwc_periph_flags_t periph_flags,
  // Pins, asynchronous
  input wire logic nmi_pin_n,
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_b_pin,
  input wire logic [7:0] port_c_pin
);

  // Registered state and its next value
  lwc_state_t st;
  lwc_state_t next_st;

  // Synchronised pin levels
  logic [24:0] pins_sync;
  logic nmi_s;
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [7:0] pc_s;

  // Request terms
  logic [4:1] vec_raw;
  logic maskable_any;
  logic external_any;
  logic wake_wait;
  logic wake_stop;
  logic pending;
  logic wdg_active;
  logic stab_done;

  // Bus decode
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic writable;
  logic [31:0] rd_word;

  // All pin levels through one two-flop chain
  lwc_sync #(
    .WIDTH(25)
  ) u_pin_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({nmi_pin_n, port_a_pin, port_b_pin, port_c_pin}),
    .sync_out(pins_sync)
  );

  assign {nmi_s, pa_s, pb_s, pc_s} = pins_sync;

  // Stabilisation timer restarted with the oscillator
  lwc_stab_counter #(
    .CYCLES(STAB_CYCLES)
  ) u_stab (
    .clk(clk),
    .reset_n(reset_n),
    .start(st.stab_start),
    .done(stab_done)
  );

  // Where execution goes, from saved context and wake kind
  function automatic lwc_resume_t resume_of(
    input lwc_core_mode_t mode,
    input logic by_nmi
  );
    lwc_resume_t r;
    r = RES_SERVICE_THEN_NEXT;
    unique case (mode)
      CORE_NORMAL: r = RES_SERVICE_THEN_NEXT;
      CORE_NMI: r = RES_NEXT_STAY_NMI;
      CORE_IRQ:
      begin
        if (by_nmi)
        begin
          r = RES_NMI_THEN_ROUTINE;
        end
        else
        begin
          r = RES_NEXT_IN_ROUTINE;
        end
      end
      // Illegal context code treated as main program
      default: r = RES_SERVICE_THEN_NEXT;
    endcase
    return r;
  endfunction : resume_of

  // Request mapping and wake qualification
  always_comb
  begin
    // Pin enabled when option set, data clear
    vec_raw[VEC_PORT_AB] = |(~pa_s & st.pa_opt & ~st.pa_dat)
      | |(~pb_s & st.pb_opt & ~st.pb_dat);
    vec_raw[VEC_PORT_C] = |(~pc_s & st.pc_opt & ~st.pc_dat);
    vec_raw[VEC_RELOAD] =
      (periph_flags.reload_overflow_flag & st.irq_en[EN_RLD_OVF_BIT])
      | (periph_flags.compare_match_flag & st.irq_en[EN_CMP_BIT])
      | (periph_flags.input_edge_flag & st.irq_en[EN_EDGE_BIT]);
    vec_raw[VEC_TIMER] =
      (periph_flags.timer_zero_flag & st.irq_en[EN_TIMER_BIT])
      | (periph_flags.converter_eoc_flag & st.irq_en[EN_CONV_BIT]);
    maskable_any = |vec_raw;
    // Only pins and NMI are external sources
    external_any = vec_raw[VEC_PORT_AB] | vec_raw[VEC_PORT_C]
      | st.nmi_latch;
    // OR of enabled requests, qualified by GEN
    // GEN low stops even NMI from waking
    wake_wait = st.global_irq_enable & (maskable_any | st.nmi_latch);
    // Stop only ends on external request
    wake_stop = st.global_irq_enable & external_any;
    // Any GEN-qualified request or NMI, whatever core_mode
    pending = (st.global_irq_enable & maskable_any) | st.nmi_latch;
    wdg_active = watchdog_hw_option | st.wdg_soft;
  end

  // Requests presented to the core
  always_comb
  begin
    irq_vector[VEC_NMI] = st.nmi_latch;
    irq_vector[4:1] = vec_raw
      & {4{st.global_irq_enable & (core_mode == CORE_NORMAL)}};
  end

  // APB phase and address decode
  always_comb
  begin
    setup_ph = apb_req.psel & ~apb_req.penable;
    access_ph = apb_req.psel & apb_req.penable;
    writable = 1'b1;
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (apb_req.paddr)
      // Write-only: reads as zero
      IOC_OFFSET: rd_word = 32'h0000_0000;
      IRQ_EN_OFFSET:
      begin
        rd_word[4:0] = st.irq_en;
        rd_word[EN_WDG_SOFT_BIT] = st.wdg_soft;
        rd_word[EN_OSC_SEL_BIT] = st.osc_sel;
      end
      PORT_A_OFFSET: rd_word[15:0] = {st.pa_dat, st.pa_opt};
      PORT_B_OFFSET: rd_word[15:0] = {st.pb_dat, st.pb_opt};
      PORT_C_OFFSET: rd_word[15:0] = {st.pc_dat, st.pc_opt};
      STATUS_OFFSET:
      begin
        writable = 1'b0;
        rd_word[ST_PWR_LSB+:2] = st.pwr;
        rd_word[ST_RES_LSB+:2] = st.resume;
        rd_word[ST_NMI_BIT] = st.nmi_latch;
        rd_word[ST_VEC_LSB+:5] = irq_vector;
        rd_word[ST_WDG_BIT] = wdg_active;
      end
      // Unmapped: zero data and an error
      default:
      begin
        mapped = 1'b0;
        writable = 1'b0;
      end
    endcase
  end

  // No wait states; error on unmapped or read-only write
  assign pready = 1'b1;
  assign pslverr = access_ph & (~mapped | (apb_req.pwrite & ~writable));

  // Next-state logic
  always_comb
  begin
    next_st = st;
    next_st.wake_pulse = 1'b0;
    next_st.reject_pulse = 1'b0;
    next_st.stab_start = 1'b0;

    // Read data captured in setup, shown in access
    if (setup_ph & ~apb_req.pwrite)
    begin
      next_st.prdata = rd_word;
    end

    // Register writes at the access edge
    if (access_ph & apb_req.pwrite & writable)
    begin
      unique case (apb_req.paddr)
        IOC_OFFSET:
        begin
          next_st.global_irq_enable = apb_req.pwdata[IOC_GEN_BIT];
        end
        IRQ_EN_OFFSET:
        begin
          next_st.irq_en = apb_req.pwdata[4:0];
          next_st.wdg_soft = apb_req.pwdata[EN_WDG_SOFT_BIT];
          next_st.osc_sel = apb_req.pwdata[EN_OSC_SEL_BIT];
        end
        PORT_A_OFFSET:
        begin
          next_st.pa_opt = apb_req.pwdata[CFG_OPT_LSB+:8];
          next_st.pa_dat = apb_req.pwdata[CFG_DAT_LSB+:8];
        end
        PORT_B_OFFSET:
        begin
          next_st.pb_opt = apb_req.pwdata[CFG_OPT_LSB+:8];
          next_st.pb_dat = apb_req.pwdata[CFG_DAT_LSB+:8];
        end
        PORT_C_OFFSET:
        begin
          next_st.pc_opt = apb_req.pwdata[CFG_OPT_LSB+:8];
          next_st.pc_dat = apb_req.pwdata[CFG_DAT_LSB+:8];
        end
        // Read-only and unmapped writes change nothing
        default:
        begin
          next_st.pc_opt = st.pc_opt;
        end
      endcase
    end

    // NMI falling edge latch; a new edge beats the ack
    next_st.nmi_prev = nmi_s;
    if (st.nmi_prev & ~nmi_s)
    begin
      next_st.nmi_latch = 1'b1;
    end
    else if (nmi_ack)
    begin
      next_st.nmi_latch = 1'b0;
    end

    // Power state machine
    unique case (st.pwr)
      PWR_RUN:
      begin
        if (wait_req | stop_req)
        begin
          if (pending)
          begin
            next_st.reject_pulse = 1'b1;
          end
          else if (stop_req & ~wdg_active)
          begin
            next_st.pwr = PWR_STOP;
            next_st.saved_mode = core_mode;
          end
          else
          begin
            next_st.pwr = PWR_WAIT;
            next_st.saved_mode = core_mode;
          end
        end
      end
      PWR_WAIT:
      begin
        // Straight back to run, no delay
        if (wake_wait)
        begin
          next_st.pwr = PWR_RUN;
          next_st.wake_pulse = 1'b1;
          next_st.resume = resume_of(st.saved_mode, st.nmi_latch);
        end
      end
      PWR_STOP:
      begin
        if (wake_stop)
        begin
          next_st.pwr = PWR_STAB;
          next_st.stab_start = 1'b1;
          next_st.resume = resume_of(st.saved_mode, st.nmi_latch);
        end
      end
      PWR_STAB:
      begin
        if (stab_done)
        begin
          next_st.pwr = PWR_RUN;
          next_st.wake_pulse = 1'b1;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    // Reset from any power state back to run
    if (!reset_n)
    begin
      st <= STATE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs from registered state
  always_comb
  begin
    prdata = st.prdata;
    // No fetch while waiting, clocks stay on
    core_halt = (st.pwr != PWR_RUN);
    osc_enable = (st.pwr != PWR_STOP);
    osc_select = st.osc_sel;
    resume_action = st.resume;
    wake_done = st.wake_pulse;
    instr_rejected = st.reject_pulse;
  end

endmodule : lwc_wake_control

// file: testbench/lwc_wake_assertions.sv
/* Port checker for lwc_wake_control.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/1ps
module lwc_wake_assertions
  import lwc_pkg::*;
#(
  parameter int unsigned STAB_CYCLES = STAB_CYCLES_DFLT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus
  input wire lwc_apb_req_t apb_req,
  input wire logic pslverr,
  // Core and oscillator
  input wire logic wait_req,
  input wire logic stop_req,
  input wire logic watchdog_hw_option,
  input wire logic core_halt,
  input wire logic wake_done,
  input wire logic instr_rejected,
  input wire logic osc_enable,
  input wire logic osc_select
);
  // Core clock, quiet in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  chk_err_access: assert property (
    pslverr |-> apb_req.psel && apb_req.penable)
    else $error("slave error outside access");
  chk_reject_cause: assert property (
    instr_rejected |-> !core_halt && $past(wait_req || stop_req))
    else $error("refusal without request");
  chk_halt_entry: assert property (
    !core_halt && (wait_req || stop_req) |=> core_halt ^ instr_rejected)
    else $error("request neither halted nor refused");
  chk_osc_stop: assert property (
    !osc_enable |-> core_halt)
    else $error("oscillator off while running");
  chk_wdg_stop: assert property (
    !core_halt && stop_req && watchdog_hw_option |=> osc_enable)
    else $error("stop taken with watchdog on");
  chk_wake_fall: assert property (
    wake_done |-> $fell(core_halt))
    else $error("wake pulse without halt end");
  // Plain count: a lower bound on the stabilisation length for any STAB_CYCLES of 2 or more
  chk_stab_hold: assert property (
    $rose(osc_enable) |-> core_halt [*4])
    else $error("fetch before oscillator settled");
  chk_osc_keep: assert property (
    !(apb_req.psel && apb_req.penable && apb_req.pwrite) |=> $stable(osc_select))
    else $error("oscillator select moved on its own");
endmodule : lwc_wake_assertions

bind lwc_wake_control lwc_wake_assertions #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.clk, .reset_n,
  .apb_req, .pslverr, .wait_req, .stop_req, .watchdog_hw_option, .core_halt, .wake_done,
  .instr_rejected, .osc_enable, .osc_select);

// file: testbench/lwc_core_model.sv
/* Core model: enters the NMI routine once running.
   Assumes irq_vector bit 0 shows the NMI latch. */
`timescale 1ns/1ps
module lwc_core_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // From the controller and the bench
  input wire logic core_halt,
  input wire logic nmi_seen,
  input wire logic [3:0] ack_delay,
  // To the controller
  output logic nmi_ack
);
  // Cycles the NMI has waited
  logic [3:0] cnt;
  // Halted core takes nothing; slow acks keep the latch up
  always_ff @(posedge clk)
  begin
    if (!reset_n || !nmi_seen || core_halt)
    begin
      cnt <= 4'h0;
      nmi_ack <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 4'h1;
      nmi_ack <= (cnt >= ack_delay);
    end
  end
endmodule : lwc_core_model

// file: testbench/tb.sv
/* Bench for lwc_wake_control with core model and APB master.
   Assumes the package, design and core model compiled first. */
`timescale 1ns/1ps
module tb;
  import lwc_pkg::*;
  localparam int unsigned STAB = 4;
  // Stimulus
  logic clk;
  logic reset_n = 1'b0;
  lwc_apb_req_t req = '0;
  logic wait_req = 1'b0;
  logic stop_req = 1'b0;
  lwc_core_mode_t core_mode = CORE_NORMAL;
  logic watchdog_hw_option = 1'b0;
  logic nmi_pin_n = 1'b1;
  logic [4:0] fv = '0;
  logic [23:0] pins = 24'hff_ffff;
  logic [3:0] ack_delay = 4'h0;
  // Responses
  logic [31:0] prdata;
  logic pready, pslverr, nmi_ack, core_halt, wake_done, instr_rejected;
  logic osc_enable, osc_select;
  logic [4:0] irq_vector;
  lwc_resume_t resume_action;
  lwc_periph_flags_t flags;
  // Counters and reference state
  int errors = 0;
  int checked = 0;
  int i, n;
  integer seed = 32'h2a30;
  logic [31:0] rd, rv;
  logic g;
  // Struct order runs opposite to the enable bits
  assign flags = {fv[0], fv[1], fv[2], fv[3], fv[4]};

  lwc_wake_control #(.STAB_CYCLES(STAB)) uut (.clk, .reset_n, .apb_req(req), .prdata,
    .pready, .pslverr, .wait_req, .stop_req, .core_mode, .nmi_ack, .watchdog_hw_option,
    .core_halt, .irq_vector, .resume_action, .wake_done, .instr_rejected, .osc_enable,
    .osc_select, .periph_flags(flags), .nmi_pin_n, .port_a_pin(pins[7:0]),
    .port_b_pin(pins[15:8]), .port_c_pin(pins[23:16]));
  lwc_core_model cm (.clk, .reset_n, .core_halt, .nmi_seen(irq_vector[0]), .ack_delay,
    .nmi_ack);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // One transfer; answer taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic err);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    // Request held until the completing edge
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    check(pready, 1'b1);
    check(pslverr, err);
    // Release only after the completing edge
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic set_gen(input logic v);
    g = v;
    apb(1'b1, IOC_OFFSET, {27'h0, v, 4'h0}, 1'b0);
  endtask : set_gen

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    fv <= '0;
    nmi_pin_n <= 1'b1;
    core_mode <= CORE_NORMAL;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    g = 1'b0;
  endtask : do_reset

  // One-cycle wait or stop request, then look mid-cycle
  task automatic pulse(input logic stp);
    @(posedge clk);
    if (stp)
      stop_req <= 1'b1;
    else
      wait_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    wait_req <= 1'b0;
    @(negedge clk);
  endtask : pulse

  // wait ends on the next edge
  task automatic flag_wake(input logic [4:0] f);
    @(posedge clk);
    fv <= f;
    @(posedge clk);
    @(negedge clk);
    check(core_halt, 1'b0);
    check(wake_done, 1'b1);
  endtask : flag_wake

  task automatic halt_cycles();
    n = 0;
    while (core_halt === 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
  endtask : halt_cycles

  initial
  begin
    do_reset();
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, IRQ_EN_OFFSET + 8'(4 * i), '0, 1'b0);
      check(rd, '0);
    end
    for (i = 0; i < 3; i++)
    begin
      rv = $random(seed);
      apb(1'b1, PORT_A_OFFSET + 8'(4 * i), rv, 1'b0);
      apb(1'b0, PORT_A_OFFSET + 8'(4 * i), '0, 1'b0);
      check(rd, {16'h0000, rv[15:0]});
    end
    apb(1'b0, 8'he0, '0, 1'b1);
    apb(1'b1, STATUS_OFFSET, 32'h0000_0003, 1'b1);
    apb(1'b0, IOC_OFFSET, '0, 1'b0);
    check(rd, '0);
    $display("test registers done");
    apb(1'b1, IRQ_EN_OFFSET, 32'h0000_001f, 1'b0);
    for (i = 0; i < 10; i++)
    begin
      set_gen(i[0]);
      @(posedge clk);
      fv <= 5'(1 << (i / 2));
      @(negedge clk);
      check(irq_vector, {27'h0, g & (i < 4), g & (i > 3), 3'h0});
    end
    for (i = 0; i < 2; i++)
    begin
      pulse(i[0]);
      check(instr_rejected, 1'b1);
      check(core_halt, 1'b0);
    end
    @(posedge clk);
    fv <= '0;
    for (i = 0; i < 3; i++)
    begin
      apb(1'b1, PORT_A_OFFSET + 8'(4 * i), 32'h0000_0001, 1'b0);
      pins <= ~(24'h1 << (8 * i));
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(irq_vector, (i == 2) ? 32'h0000_0004 : 32'h0000_0002);
      @(posedge clk);
      pins <= 24'hff_ffff;
    end
    repeat (3) @(posedge clk);
    $display("test vectors done");
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      fv <= '0;
      core_mode <= lwc_core_mode_t'(i);
      pulse(1'b0);
      check(core_halt, 1'b1);
      check(osc_enable, 1'b1);
      flag_wake(5'h10);
      check(resume_action, {31'h0, i[0]} << 1);
    end
    // wake by NMI, prompt and slow acks
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk);
      fv <= '0;
      core_mode <= lwc_core_mode_t'(i);
      ack_delay <= 4'(3 * i);
      pulse(1'b0);
      @(posedge clk);
      nmi_pin_n <= 1'b0;
      halt_cycles();
      check(wake_done, 1'b1);
      check(resume_action, {30'h0, i == 1, i != 0});
      @(posedge clk);
      nmi_pin_n <= 1'b1;
      repeat (12) @(negedge clk);
      check(irq_vector[0], 1'b0);
    end
    set_gen(1'b0);
    pulse(1'b0);
    @(posedge clk);
    fv <= 5'h1f;
    nmi_pin_n <= 1'b0;
    repeat (10) @(negedge clk);
    check(core_halt, 1'b1);
    do_reset();
    @(negedge clk);
    check(core_halt, 1'b0);
    $display("test wake done");
    apb(1'b1, IRQ_EN_OFFSET, 32'h0000_0201, 1'b0);
    apb(1'b1, PORT_C_OFFSET, 32'h0000_0001, 1'b0);
    set_gen(1'b1);
    fv <= '0;
    pins <= 24'hff_ffff;
    pulse(1'b1);
    check(osc_enable, 1'b0);
    @(posedge clk);
    fv <= 5'h01;
    repeat (6) @(posedge clk);
    pins <= 24'hfe_ffff;
    @(negedge clk);
    check(core_halt, 1'b1);
    n = 0;
    while (osc_enable !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    halt_cycles();
    // Registered start pulse and the done pulse each add one cycle
    check(n, STAB + 2);
    check(wake_done, 1'b1);
    check(osc_select, 1'b1);
    @(posedge clk);
    fv <= '0;
    pins <= 24'hff_ffff;
    watchdog_hw_option <= 1'b1;
    repeat (3) @(posedge clk);
    pulse(1'b1);
    check(osc_enable, 1'b1);
    check(core_halt, 1'b1);
    flag_wake(5'h01);
    $display("test stop done");
    tally_and_finish();
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #100_000;
    errors++;
    tally_and_finish();
  end
endmodule : tb
